// >>> include/lat_table_pkg.sv
package lat_table_pkg;
   // ****************************************
   // Latency codes and frequency limits
   // ****************************************
   localparam logic [1:0] LC_01 = 2'h1;
   localparam logic [1:0] LC_10 = 2'h2;
   localparam logic [7:0] ROW4_MHZ = 8'h5a;
   localparam logic [7:0] ROW5_MHZ = 8'h68;
   localparam logic [7:0] ROW6_MHZ = 8'h85;
   localparam logic [7:0] NOT_SUPP = 8'hff;
   localparam logic [7:0] MODE_NONE = 8'h00;
   localparam logic [7:0] DUMMY_FAST = 8'h08;
   localparam logic [7:0] DIO_MODE = 8'h04;
   localparam logic [7:0] QIO_MODE = 8'h02;
   localparam logic [7:0] DIO_DUMMY_R4 = 8'h01;
   localparam logic [7:0] QIO_DUMMY_R4 = 8'h04;
   localparam logic [7:0] DIO_DUMMY_R5 = 8'h02;
   localparam logic [7:0] QIO_DUMMY_R5 = 8'h05;
   // ****************************************
   // Double-rate parameter header
   // ****************************************
   localparam logic [7:0] DDR_PARAM_ID = 8'h9a;
   localparam logic [7:0] DDR_PARAM_LEN = 8'h2a;
   localparam logic [7:0] DDR_ROWS = 8'h05;
   localparam logic [7:0] DDR_ROW_LEN = 8'h08;
   localparam logic [7:0] HDR_FREQ = 8'h46;
   localparam logic [7:0] HDR_CODE = 8'h43;
   localparam logic [7:0] OP_FAST_DDR3 = 8'h0d;
   localparam logic [7:0] OP_FAST_DDR4 = 8'h0e;
   localparam logic [7:0] OP_DIO_DDR3 = 8'hbd;
   localparam logic [7:0] OP_DIO_DDR4 = 8'hbe;
   localparam logic [7:0] OP_QIO_DDR3 = 8'hed;
   localparam logic [7:0] OP_QIO_DDR4 = 8'hee;
   localparam int HDR_BYTES = 12;
   // ****************************************
   // Read commands
   // ****************************************
   typedef enum logic [2:0] {
      CMD_READ, CMD_FAST, CMD_DOUT, CMD_QOUT, CMD_DIO, CMD_QIO
   } read_cmd_t;
   // ****************************************
   // Latency counter
   // ****************************************
   localparam logic [7:0] CNT_RST = 8'h00;
   typedef enum logic [1:0] {
      ST_IDLE, ST_MODE, ST_DUMMY, ST_DATA
   } lat_state_t;
endpackage

// >>> design/lat_table.sv
`timescale 1ns/100ps
// How it works
// - Code 01b up to 90 MHz: plain read reported unsupported.
// - Code 01b: dual I/O 4 mode plus 1 dummy; quad I/O 2 plus 4.
// - Code 01b: fast, dual-out, quad-out reads use 0 mode, 8 dummy.
// - Code 10b to 104 MHz: plain unsupported; DIO 4+2, QIO 2+5; others 8.
// - Code 10b to 133 MHz: only fast read, 0 mode and 8 dummy.
// - Entry FFh marks a command unsupported for that row.
// - Row byte 0 holds frequency limit in MHz.
// - Row byte 1 holds the two-bit latency code.
// - Double-rate parameter opens with identifier 9Ah.
// - Length byte counts following bytes; next parameter at loc+len+1.
// - Double-rate header row starts with ASCII F then C.
// - Double-rate fast read opcodes 0Dh (3-byte) and 0Eh (4-byte).
// - Double-rate dual I/O opcodes BDh and BEh.
// - Double-rate quad I/O 3-byte opcode EDh.
// - Double-rate quad I/O 4-byte opcode EEh.
module lat_table
   import lat_table_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [1:0] lat_code_in,
   input wire logic fast_clk_in,
   input wire logic [2:0] cmd_in,
   input wire logic start_in,
   input wire logic sck_in,
   input wire logic [3:0] qry_addr_in,
   output logic [7:0] row_freq_out,
   output logic [7:0] row_code_out,
   output logic [7:0] mode_cyc_out,
   output logic [7:0] dummy_cyc_out,
   output logic unsupported_out,
   output logic busy_out,
   output logic data_phase_out,
   output logic [7:0] qry_data_out
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] sck_sync;
      logic sck_prev;
      lat_state_t st;
      logic [7:0] cnt;
      logic [7:0] row_freq;
      logic [7:0] row_code;
      logic [7:0] mode_cyc;
      logic [7:0] dummy_cyc;
      logic unsupp;
      logic [7:0] qry;
   } state_t;

   state_t cur_ff;
   state_t nxt_ff;

   // ****************************************
   // Table lookup
   // ****************************************
   // Returns {mode, dummy}; FFh in both marks a refused command
   function automatic logic [15:0] lookup(input logic [1:0] code,
                                          input logic fast,
                                          input logic [2:0] cmd);
      logic [15:0] r;
      r = {NOT_SUPP, NOT_SUPP};
      if (code == LC_01) begin
         case (cmd)
            CMD_FAST, CMD_DOUT, CMD_QOUT: begin
               r = {MODE_NONE, DUMMY_FAST};
            end
            CMD_DIO: r = {DIO_MODE, DIO_DUMMY_R4};
            CMD_QIO: r = {QIO_MODE, QIO_DUMMY_R4};
            default: r = {NOT_SUPP, NOT_SUPP};
         endcase
      end else if (code == LC_10 && !fast) begin
         case (cmd)
            CMD_FAST, CMD_DOUT, CMD_QOUT: begin
               r = {MODE_NONE, DUMMY_FAST};
            end
            CMD_DIO: r = {DIO_MODE, DIO_DUMMY_R5};
            CMD_QIO: r = {QIO_MODE, QIO_DUMMY_R5};
            default: r = {NOT_SUPP, NOT_SUPP};
         endcase
      end else if (code == LC_10) begin
         if (cmd == CMD_FAST) begin
            r = {MODE_NONE, DUMMY_FAST};
         end
      end
      return r;
   endfunction

   // ****************************************
   // Query header
   // ****************************************
   // Offsets past the header read 00h, never a stray opcode
   function automatic logic [7:0] hdr_byte(input logic [3:0] a);
      case (a)
         4'h0: hdr_byte = DDR_PARAM_ID;
         4'h1: hdr_byte = DDR_PARAM_LEN;
         4'h2: hdr_byte = DDR_ROWS;
         4'h3: hdr_byte = DDR_ROW_LEN;
         4'h4: hdr_byte = HDR_FREQ;
         4'h5: hdr_byte = HDR_CODE;
         4'h6: hdr_byte = OP_FAST_DDR3;
         4'h7: hdr_byte = OP_FAST_DDR4;
         4'h8: hdr_byte = OP_DIO_DDR3;
         4'h9: hdr_byte = OP_DIO_DDR4;
         4'ha: hdr_byte = OP_QIO_DDR3;
         4'hb: hdr_byte = OP_QIO_DDR4;
         default: hdr_byte = 8'h00;
      endcase
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   logic [15:0] lk;
   logic [7:0] lk_mode;
   logic [7:0] lk_dummy;
   logic sck_rise;

   // Split once so each field is named where it is tested
   assign lk = lookup(lat_code_in, fast_clk_in, cmd_in);
   assign lk_mode = lk[15:8];
   assign lk_dummy = lk[7:0];

   always_comb begin
      nxt_ff = cur_ff;
      // SCK must stay high and low for two mclk periods each
      nxt_ff.sck_sync = {cur_ff.sck_sync[0], sck_in};
      nxt_ff.sck_prev = cur_ff.sck_sync[1];
      sck_rise = cur_ff.sck_sync[1] && !cur_ff.sck_prev;
      // Row selected by code and clock range
      if (lat_code_in == LC_01) begin
         nxt_ff.row_freq = ROW4_MHZ;
      end else if (fast_clk_in) begin
         nxt_ff.row_freq = ROW6_MHZ;
      end else begin
         nxt_ff.row_freq = ROW5_MHZ;
      end
      nxt_ff.row_code = {6'h00, lat_code_in};
      nxt_ff.qry = hdr_byte(qry_addr_in);

      case (cur_ff.st)
         ST_IDLE: begin
            nxt_ff.mode_cyc = lk_mode;
            nxt_ff.dummy_cyc = lk_dummy;
            // Refused command leaves the machine idle with the flag up
            nxt_ff.unsupp = (lk_mode == NOT_SUPP);
            if (start_in && lk_mode != NOT_SUPP) begin
               // Counts latched per read so a code change mid-read is safe
               nxt_ff.cnt = CNT_RST;
               if (lk_mode != MODE_NONE) begin
                  nxt_ff.st = ST_MODE;
               end else begin
                  nxt_ff.st = ST_DUMMY;
               end
            end
         end
         ST_MODE: begin
            // Host deselect cuts the read; no half-count is left behind
            if (!start_in) begin
               nxt_ff.cnt = CNT_RST;
               nxt_ff.st = ST_IDLE;
            end else if (sck_rise) begin
               if (cur_ff.cnt + 8'h01 == cur_ff.mode_cyc) begin
                  nxt_ff.cnt = CNT_RST;
                  if (cur_ff.dummy_cyc == 8'h00) begin
                     nxt_ff.st = ST_DATA;
                  end else begin
                     nxt_ff.st = ST_DUMMY;
                  end
               end else begin
                  nxt_ff.cnt = cur_ff.cnt + 8'h01;
               end
            end
         end
         ST_DUMMY: begin
            if (!start_in) begin
               nxt_ff.cnt = CNT_RST;
               nxt_ff.st = ST_IDLE;
            end else if (sck_rise) begin
               if (cur_ff.cnt + 8'h01 == cur_ff.dummy_cyc) begin
                  nxt_ff.cnt = CNT_RST;
                  nxt_ff.st = ST_DATA;
               end else begin
                  nxt_ff.cnt = cur_ff.cnt + 8'h01;
               end
            end
         end
         ST_DATA: begin
            // Data phase holds until the host deselects
            if (!start_in) begin
               nxt_ff.st = ST_IDLE;
            end
         end
         default: nxt_ff.st = ST_IDLE;
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   // Low enable holds every field, synchroniser included
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cur_ff <= '0;
      end else if (ce_in) begin
         cur_ff <= nxt_ff;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign row_freq_out = cur_ff.row_freq;
   assign row_code_out = cur_ff.row_code;
   assign mode_cyc_out = cur_ff.mode_cyc;
   assign dummy_cyc_out = cur_ff.dummy_cyc;
   assign unsupported_out = cur_ff.unsupp;
   assign busy_out = (cur_ff.st == ST_MODE) || (cur_ff.st == ST_DUMMY);
   assign data_phase_out = (cur_ff.st == ST_DATA);
   assign qry_data_out = cur_ff.qry;
endmodule

// >>> verification/lat_table_properties.sv
`timescale 1ns/100ps
module lat_table_properties
   import lat_table_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [1:0] lat_code_in,
   input wire logic fast_clk_in,
   input wire logic [2:0] cmd_in,
   input wire logic start_in,
   input wire logic sck_in,
   input wire logic [3:0] qry_addr_in,
   input wire logic [7:0] row_freq_out,
   input wire logic [7:0] row_code_out,
   input wire logic [7:0] mode_cyc_out,
   input wire logic [7:0] dummy_cyc_out,
   input wire logic unsupported_out,
   input wire logic busy_out,
   input wire logic data_phase_out,
   input wire logic [7:0] qry_data_out
);
   logic idl;
   // Lookups only track inputs outside a read
   assign idl = ce_in && !busy_out && !data_phase_out && !start_in;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   unsup_flag_a: assert property (
      unsupported_out == (mode_cyc_out == NOT_SUPP) &&
      (mode_cyc_out == NOT_SUPP) == (dummy_cyc_out == NOT_SUPP))
      else $error("flag");
   plain_read_a: assert property (idl && cmd_in == CMD_READ |=>
      mode_cyc_out == NOT_SUPP && dummy_cyc_out == NOT_SUPP) else $error("rd");
   dio_slow_a: assert property (idl && lat_code_in == LC_01 &&
      cmd_in == CMD_DIO |=> mode_cyc_out == DIO_MODE &&
      dummy_cyc_out == DIO_DUMMY_R4) else $error("dio");
   qio_mid_a: assert property (idl && lat_code_in == LC_10 &&
      !fast_clk_in && cmd_in == CMD_QIO |=> mode_cyc_out == QIO_MODE &&
      dummy_cyc_out == QIO_DUMMY_R5) else $error("qio");
   fast_only_a: assert property (idl && lat_code_in == LC_10 &&
      fast_clk_in |=> unsupported_out == ($past(cmd_in) != CMD_FAST))
      else $error("fast");
   row_freq_a: assert property (idl && lat_code_in == LC_01 |=>
      row_freq_out == ROW4_MHZ) else $error("freq");
   row_code_a: assert property (idl |=>
      row_code_out == {6'h0, $past(lat_code_in)}) else $error("code");
   qry_len_a: assert property (ce_in && qry_addr_in == 4'h1 |=>
      qry_data_out == DDR_PARAM_LEN) else $error("len");
   phase_end_a: assert property (data_phase_out && ce_in &&
      !start_in |=> !data_phase_out && !busy_out) else $error("end");
   read_abort_a: assert property (busy_out && ce_in &&
      !start_in |=> !busy_out && !data_phase_out) else $error("abort");
endmodule
bind lat_table lat_table_properties u_props (.mclk_in(mclk_in),
   .rst_in(rst_in), .ce_in(ce_in), .lat_code_in(lat_code_in),
   .fast_clk_in(fast_clk_in), .cmd_in(cmd_in), .start_in(start_in),
   .sck_in(sck_in), .qry_addr_in(qry_addr_in), .row_freq_out(row_freq_out),
   .row_code_out(row_code_out), .mode_cyc_out(mode_cyc_out),
   .dummy_cyc_out(dummy_cyc_out), .unsupported_out(unsupported_out),
   .busy_out(busy_out), .data_phase_out(data_phase_out),
   .qry_data_out(qry_data_out));

// >>> verification/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
   input wire logic run_in,
   output logic sck_out
);
   // ****
   // Serial clock, low outside frames
   // ****
   initial begin
      sck_out = 1'b0;
      // Offset keeps SCK edges clear of the bench's drive edge
      #10;
      forever begin
         #200;
         sck_out = run_in ? ~sck_out : 1'b0;
      end
   end
endmodule

// >>> verification/tb_lat_table.sv
`timescale 1ns/100ps
module tb_lat_table
   import lat_table_pkg::*;
;
   logic mclk_in = 1'b0, rst_in, ce_in, fast_clk_in, start_in, sck_in;
   logic [1:0] lat_code_in;
   logic [2:0] cmd_in;
   logic [3:0] qry_addr_in;
   logic [7:0] rf, rc, mc, dc, qd;
   logic [7:0] sck_cnt = 8'h00;
   logic uns, busy, dph;
   int bad_count = 0, check_count = 0;
   logic [15:0] tbl [3][6] = '{
      '{16'hffff, 16'h0008, 16'h0008, 16'h0008, 16'h0401, 16'h0204},
      '{16'hffff, 16'h0008, 16'h0008, 16'h0008, 16'h0402, 16'h0205},
      '{16'hffff, 16'h0008, 16'hffff, 16'hffff, 16'hffff, 16'hffff}};
   logic [7:0] frq [3] = '{8'h5a, 8'h68, 8'h85};
   logic [7:0] hdr [13] = '{8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
      8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h00};
   always #25 mclk_in = ~mclk_in;
   always @(posedge sck_in) sck_cnt <= sck_cnt + 8'h1;
   spi_host_model u_host (.run_in(start_in), .sck_out(sck_in));
   lat_table u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
      .lat_code_in(lat_code_in), .fast_clk_in(fast_clk_in),
      .cmd_in(cmd_in), .start_in(start_in), .sck_in(sck_in),
      .qry_addr_in(qry_addr_in), .row_freq_out(rf), .row_code_out(rc),
      .mode_cyc_out(mc), .dummy_cyc_out(dc), .unsupported_out(uns),
      .busy_out(busy), .data_phase_out(dph), .qry_data_out(qd));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task look_rows;
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 6; c++) begin
            @(negedge mclk_in);
            lat_code_in = (r == 0) ? LC_01 : LC_10;
            fast_clk_in = (r == 2);
            cmd_in = c[2:0];
            @(negedge mclk_in);
            chk(mc, tbl[r][c][15:8]);
            chk(dc, tbl[r][c][7:0]);
            chk({7'h0, uns}, {7'h0, tbl[r][c] == 16'hffff});
            chk(rf, frq[r]);
            chk(rc, {6'h0, lat_code_in});
         end
      end
   endtask
   task query_hdr;
      for (int a = 0; a < 13; a++) begin
         @(negedge mclk_in);
         qry_addr_in = a[3:0];
         @(negedge mclk_in);
         chk(qd, hdr[a]);
      end
      ce_in = 1'b0;
      qry_addr_in = 4'h0;
      repeat (2) @(negedge mclk_in);
      chk(qd, 8'h00);
      ce_in = 1'b1;
   endtask
   task automatic read_one(input logic [1:0] lc, input logic fc,
      input logic [2:0] cm, input logic [7:0] n);
      int w;
      logic [7:0] base;
      @(negedge mclk_in);
      lat_code_in = lc;
      fast_clk_in = fc;
      cmd_in = cm;
      base = sck_cnt;
      start_in = 1'b1;
      @(negedge mclk_in);
      chk({7'h0, busy}, 8'h01);
      w = 0;
      while (dph !== 1'b1 && w < 400) begin
         @(negedge mclk_in);
         w++;
      end
      chk({7'h0, dph}, 8'h01);
      chk(sck_cnt - base, n);
      start_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      chk({6'h0, busy, dph}, 8'h0);
   endtask
   task read_cut;
      @(negedge mclk_in);
      lat_code_in = LC_01;
      fast_clk_in = 1'b0;
      cmd_in = CMD_QIO;
      start_in = 1'b1;
      repeat (20) @(negedge mclk_in);
      chk({6'h0, busy, dph}, 8'h02);
      start_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      chk({6'h0, busy, dph}, 8'h00);
   endtask
   task read_refused;
      @(negedge mclk_in);
      lat_code_in = LC_10;
      fast_clk_in = 1'b1;
      cmd_in = CMD_DIO;
      start_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      chk({6'h0, busy, uns}, 8'h01);
      start_in = 1'b0;
   endtask
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
   initial begin
      {rst_in, ce_in, fast_clk_in, start_in} = 4'hc;
      lat_code_in = LC_01;
      cmd_in = CMD_FAST;
      qry_addr_in = 4'h0;
      repeat (12) @(negedge mclk_in);
      rst_in = 1'b0;
      look_rows;
      query_hdr;
      read_one(LC_01, 1'b0, CMD_DIO, 8'h05);
      read_one(LC_10, 1'b0, CMD_QIO, 8'h07);
      read_one(LC_10, 1'b1, CMD_FAST, 8'h08);
      read_cut;
      read_refused;
      give_verdict;
   end
endmodule
